/* logic/wdog_pkg.sv */
// package: constants, register offsets and reset values of the reload-counter watchdog
// Function
// - sixteen-bit down counter, reload from two bytes
// - only on or off; counts until retriggered
// - enable by refresh or always-on option zero
// - reload value is high byte then low
// - reload value resets to 0400 hex
// - one decrement per watchdog oscillator tick
// - first enable loads reload, counts toward zero
// - refresh instruction reloads counter, counting resumes
// - debugger halt retriggers counter continuously
// - zero count is time-out, response per option
// - interrupt mode raises request, sets watchdog flag
// - interrupt mode time-out lets counter roll over
// - interrupt mode stop time-out: recovery, both flags
// - reset mode time-out outside stop forces reset
// - system reset returns counter to reset value
// - reset mode stop time-out: recovery, both flags
// - unlock is 55h then AAh to high
// - unlock writes keep high; locked writes ignored
// - high then low written; low write relocks
// - reload addresses read back the live count
package wdog_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] ADDR_RELOAD_HIGH = 12'h0FF2; // reload_high_byte
    localparam logic [11:0] ADDR_RELOAD_LOW = 12'h0FF3; // reload_low_byte
    localparam logic [11:0] ADDR_CAUSE = 12'h0FF4; // reset_cause_register copy
    localparam int CAUSE_WDOG_BIT = 5; // watchdog flag position
    localparam int CAUSE_STOP_BIT = 4; // stop flag position
    // ****************************************
    // reset values and unlock keys
    // ****************************************
    localparam logic [15:0] RELOAD_RESET = 16'h0400;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
    // ****************************************
    // timing
    // ****************************************
    localparam int MCLK_HZ = 200_000_000;
    localparam int WDOG_OSC_HZ = 10_000; // nominal watchdog oscillator rate
    localparam int WDOG_TICK_CYCLES = MCLK_HZ / WDOG_OSC_HZ;
    // ****************************************
    // unlock tracker states, one-hot
    // ****************************************
    typedef enum logic [3:0] {
        LOCKED = 4'b0001,
        GOT_FIRST = 4'b0010,
        WANT_HIGH = 4'b0100,
        WANT_LOW = 4'b1000
    } unlock_state_t;
endpackage

/* logic/wdog_tick_if.sv */
// interface: watchdog oscillator tick carried from the divider to the counter
`timescale 1ns/1ps
`default_nettype none
interface wdog_tick_if;
    logic tick; // one-cycle pulse per watchdog oscillator period
    modport source (output tick);
    modport sink (input tick);
endinterface
`default_nettype wire

/* logic/wdog_tick_div.sv */
// module: divides mclk down to the watchdog oscillator tick enable
`timescale 1ns/1ps
`default_nettype none
module wdog_tick_div #(
    parameter int DIVIDE = wdog_pkg::WDOG_TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    wdog_tick_if.source tick_out
);
    import wdog_pkg::*;
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] count; // cycles left in this period
        logic tick; // registered pulse
    } div_state_t;
    div_state_t s_q;
    div_state_t s_d;
    initial begin
        if (DIVIDE < 1) begin
            $error("divide must be at least one");
        end
    end
    // next state: pulse once every DIVIDE cycles
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.count == 32'h0000_0000) begin
            s_d.count = 32'(DIVIDE - 1);
            s_d.tick = 1'b1;
        end else begin
            s_d.count = s_q.count - 32'h0000_0001;
        end
    end
    // register the state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick_out.tick = s_q.tick;
endmodule
`default_nettype wire

/* logic/wdog_reload_counter.sv */
// module: reload-counter watchdog with unlock-protected reload bytes
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module wdog_reload_counter #(
    parameter int TICK_CYCLES = wdog_pkg::WDOG_TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic refresh_exec,
    input wire logic debug_halt,
    input wire logic stop_mode,
    input wire logic always_on_option,
    input wire logic timeout_response_option,
    output logic wdog_irq,
    output logic stop_recovery,
    output logic system_reset_req,
    output logic wdog_running
);
    import wdog_pkg::*;
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic on; // watchdog switched on
        logic [15:0] count; // live down counter
        logic [7:0] reload_high; // reload_high_byte
        logic [7:0] reload_low; // reload_low_byte
        unlock_state_t unlock; // unlock tracker
        logic flag_wdog; // watchdog cause flag
        logic flag_stop; // stop cause flag
        logic [7:0] rdata; // read data, one cycle after strobe
        logic irq; // interrupt request level
        logic recover; // stop recovery pulse
        logic rst_req; // system reset pulse
    } wdog_state_t;
    wdog_state_t s_q;
    wdog_state_t s_d;
    wdog_tick_if tick_bus ();
    logic [15:0] reload_value; // assembled reload word
    logic timeout; // counter hits zero on a tick
    initial begin
        if (TICK_CYCLES < 1) begin
            $error("tick cycles must be at least one");
        end
    end
    // ****************************************
    // oscillator tick
    // ****************************************
    wdog_tick_div #(
        .DIVIDE(TICK_CYCLES)
    ) u_div (
        .mclk(mclk),
        .reset(reset),
        .tick_out(tick_bus.source)
    );
    // high byte on top of low byte
    assign reload_value = {s_q.reload_high, s_q.reload_low};
    // zero reached while running and not held by the debugger
    assign timeout = s_q.on && tick_bus.tick && !debug_halt && !refresh_exec
        && (s_q.count == 16'h0001);
    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.recover = 1'b0;
        s_d.rst_req = 1'b0;
        s_d.rdata = 8'h00;
        // enabling: refresh or the always-on option at zero
        if (!s_q.on && (refresh_exec || !always_on_option)) begin
            s_d.on = 1'b1;
            s_d.count = reload_value;
        end else if (s_q.on) begin
            if (refresh_exec || debug_halt) begin
                // retrigger keeps running afterwards
                s_d.count = reload_value;
            end else if (tick_bus.tick) begin
                // plain decrement; after zero it wraps
                s_d.count = s_q.count - 16'h0001;
            end
        end
        // time-out response
        if (timeout) begin
            s_d.flag_wdog = 1'b1;
            if (stop_mode) begin
                // stop mode always recovers, both flags set
                s_d.flag_stop = 1'b1;
                s_d.recover = 1'b1;
                s_d.irq = !timeout_response_option ? 1'b1 : s_q.irq;
            end else if (!timeout_response_option) begin
                s_d.irq = 1'b1; // interrupt response
            end else begin
                s_d.rst_req = 1'b1; // reset response
            end
        end
        // register writes
        if (reg_write) begin
            if (reg_addr == ADDR_RELOAD_HIGH) begin
                case (s_q.unlock)
                    LOCKED: begin
                        // keys never touch the high byte
                        s_d.unlock = (reg_wdata == UNLOCK_KEY_FIRST) ? GOT_FIRST : LOCKED;
                    end
                    GOT_FIRST: begin
                        s_d.unlock = (reg_wdata == UNLOCK_KEY_SECOND) ? WANT_HIGH : LOCKED;
                    end
                    WANT_HIGH: begin
                        s_d.reload_high = reg_wdata;
                        s_d.unlock = WANT_LOW;
                    end
                    default: begin
                        s_d.unlock = LOCKED; // out of order
                    end
                endcase
            end else if (reg_addr == ADDR_RELOAD_LOW) begin
                if (s_q.unlock == WANT_LOW) begin
                    s_d.reload_low = reg_wdata; // relock on low write
                end
                s_d.unlock = LOCKED; // locked or out of order
            end else if (reg_addr == ADDR_CAUSE) begin
                // writing zero clears a flag; a same-cycle time-out wins
                if (!reg_wdata[CAUSE_WDOG_BIT] && !timeout) begin
                    s_d.flag_wdog = 1'b0;
                    s_d.irq = 1'b0;
                end
                if (!reg_wdata[CAUSE_STOP_BIT] && !(timeout && stop_mode)) begin
                    s_d.flag_stop = 1'b0;
                end
            end
        end
        // register reads: reload addresses show the live count
        if (reg_read) begin
            if (reg_addr == ADDR_RELOAD_HIGH) begin
                s_d.rdata = s_q.count[15:8];
            end else if (reg_addr == ADDR_RELOAD_LOW) begin
                s_d.rdata = s_q.count[7:0];
            end else if (reg_addr == ADDR_CAUSE) begin
                s_d.rdata[CAUSE_WDOG_BIT] = s_q.flag_wdog;
                s_d.rdata[CAUSE_STOP_BIT] = s_q.flag_stop;
            end
        end
    end
    // ****************************************
    // registers; reset restores reload and counter
    // ****************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.count <= RELOAD_RESET;
            s_q.reload_high <= RELOAD_RESET[15:8];
            s_q.reload_low <= RELOAD_RESET[7:0];
            s_q.unlock <= LOCKED;
        end else begin
            s_q <= s_d;
        end
    end
    // outputs straight from flip-flops
    assign reg_rdata = s_q.rdata;
    assign wdog_irq = s_q.irq;
    assign stop_recovery = s_q.recover;
    assign system_reset_req = s_q.rst_req;
    assign wdog_running = s_q.on;
endmodule
`default_nettype wire

/* verification/wdog_reload_counter_props.sv */
// checker: port-level properties of the reload-counter watchdog
`timescale 1ns/1ps
`default_nettype none
module wdog_reload_counter_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic debug_halt,
    input wire logic stop_mode,
    input wire logic always_on_option,
    input wire logic timeout_response_option,
    input wire logic wdog_irq,
    input wire logic stop_recovery,
    input wire logic system_reset_req,
    input wire logic wdog_running
);
    // **********************************
    // properties
    // **********************************
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic clr_w; // any write to the cause flags
    assign clr_w = reg_write && reg_addr == wdog_pkg::ADDR_CAUSE;
    // software writes the watchdog flag to zero
    sequence s_clear;
        clr_w && !reg_wdata[wdog_pkg::CAUSE_WDOG_BIT];
    endsequence
    property p_stays_on; wdog_running |=> wdog_running; endproperty
    property p_ao_on; !always_on_option |-> ##[1:2] wdog_running; endproperty
    property p_irq_mode; $rose(wdog_irq) |-> !timeout_response_option; endproperty
    // irq may only drop one or two cycles after a flag write
    property p_irq_hold; wdog_irq && !clr_w && !$past(clr_w) |=> wdog_irq; endproperty
    property p_irq_clear; wdog_irq ##0 s_clear |-> ##[1:2] !wdog_irq; endproperty
    property p_rst_pulse;
        system_reset_req |-> $past(timeout_response_option) && !$past(stop_mode) ##1 !system_reset_req;
    endproperty
    property p_recover; stop_recovery |-> !system_reset_req ##1 !stop_recovery; endproperty
    property p_halt; debug_halt [*3] |-> !system_reset_req && !stop_recovery; endproperty
    a_stays_on: assert property (p_stays_on) else $error("watchdog switched off");
    a_ao_on: assert property (p_ao_on) else $error("always-on not running");
    a_irq_mode: assert property (p_irq_mode) else $error("irq in reset mode");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
    a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
    a_rst_pulse: assert property (p_rst_pulse) else $error("bad reset pulse");
    a_recover: assert property (p_recover) else $error("bad recovery pulse");
    a_halt: assert property (p_halt) else $error("time-out under halt");
endmodule
bind wdog_reload_counter wdog_reload_counter_props i_props (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .debug_halt(debug_halt), .stop_mode(stop_mode), .always_on_option(always_on_option),
    .timeout_response_option(timeout_response_option), .wdog_irq(wdog_irq),
    .stop_recovery(stop_recovery), .system_reset_req(system_reset_req),
    .wdog_running(wdog_running));
`default_nettype wire

/* verification/core_model.sv */
// partner: processor core issuing refresh instructions
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic kick,
    output logic refresh_exec
);
    // **********************************
    // refresh issue
    // **********************************
    // one refresh a cycle after each request, like a pipelined core
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            refresh_exec <= 1'b0;
        end else begin
            refresh_exec <= kick;
        end
    end
endmodule
`default_nettype wire

/* verification/tb_wdog_reload_counter.sv */
// testbench: directed scenarios for the reload-counter watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_wdog_reload_counter;
    import wdog_pkg::*;
    // **********************************
    // stimulus and hookup
    // **********************************
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] reg_addr = 12'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic halt = 1'b0;
    logic stop = 1'b0;
    logic ao = 1'b1;
    logic resp = 1'b0;
    logic kick = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] rv;
    logic refresh_exec, irq, recov, rst_req, running;
    int err_total = 0;
    int checked = 0;
    always #2.5 mclk = ~mclk;
    core_model i_core_model (.mclk(mclk), .reset(reset), .kick(kick), .refresh_exec(refresh_exec));
    // short tick keeps every time-out within a few dozen cycles
    wdog_reload_counter #(.TICK_CYCLES(2)) i_wdog_reload_counter (.mclk(mclk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .refresh_exec(refresh_exec), .debug_halt(halt),
        .stop_mode(stop), .always_on_option(ao), .timeout_response_option(resp),
        .wdog_irq(irq), .stop_recovery(recov), .system_reset_req(rst_req),
        .wdog_running(running));
    // **********************************
    // bus and compare tasks
    // **********************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    // read data is only valid in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        rv = reg_rdata;
    endtask
    task automatic refresh();
        @(posedge mclk);
        kick <= 1'b1;
        @(posedge mclk);
        kick <= 1'b0;
    endtask
    // **********************************
    // scenarios
    // **********************************
    task automatic t_unlock();
        rd(ADDR_RELOAD_HIGH);
        chk(rv, 8'h04);
        chk({7'h00, running}, 8'h00);
        wr(ADDR_RELOAD_LOW, 8'h77);
        wr(ADDR_RELOAD_HIGH, 8'h55);
        wr(ADDR_RELOAD_HIGH, 8'hAA);
        wr(ADDR_RELOAD_HIGH, 8'h00);
        wr(ADDR_RELOAD_LOW, 8'h05);
        wr(ADDR_RELOAD_LOW, 8'h09);
        wr(ADDR_RELOAD_HIGH, 8'h55);
        wr(ADDR_RELOAD_LOW, 8'h33);
        wr(ADDR_RELOAD_HIGH, 8'hAA);
        wr(ADDR_RELOAD_HIGH, 8'h11);
        @(posedge mclk);
        halt <= 1'b1;
        refresh();
        repeat (4) @(posedge mclk);
        rd(ADDR_RELOAD_HIGH);
        chk(rv, 8'h00);
        rd(ADDR_RELOAD_LOW);
        chk(rv, 8'h05);
        chk({7'h00, running}, 8'h01);
    endtask
    // time-out with the given response and stop level, then flags cleared
    task automatic t_timeout(input logic r, input logic s, input logic [7:0] flags);
        @(posedge mclk);
        halt <= 1'b0;
        resp <= r;
        stop <= s;
        refresh();
        for (int n = 0; n < 80 && (irq | recov | rst_req) !== 1'b1; n++) @(negedge mclk);
        chk({5'h00, irq, recov, rst_req}, {5'h00, !r, s, r && !s});
        rd(ADDR_CAUSE);
        chk(rv & 8'h30, flags);
        rd(ADDR_RELOAD_HIGH);
        chk(rv, 8'hFF);
        wr(ADDR_CAUSE, 8'h00);
        repeat (3) @(negedge mclk);
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic t_always_on();
        @(posedge mclk);
        reset <= 1'b1;
        ao <= 1'b0;
        // debugger retrigger holds the count at the reload value, so the read sees it whole
        halt <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(negedge mclk);
        chk({7'h00, running}, 8'h01);
        rd(ADDR_RELOAD_HIGH);
        chk(rv, 8'h04);
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // run is under two hundred cycles; this limit only cuts a hang
    initial begin
        #20000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_unlock();
        t_timeout(1'b0, 1'b0, 8'h20);
        t_timeout(1'b1, 1'b0, 8'h20);
        t_timeout(1'b0, 1'b1, 8'h30);
        t_timeout(1'b1, 1'b1, 8'h30);
        t_always_on();
        conclude();
    end
endmodule
`default_nettype wire
